/* rtl/vbs_top.sv */
// video bus sharing, dram refresh, raster compare, light pen and interrupt latches
`timescale 1ns/1ps
`default_nettype none
`include "vbs_defs.svh"

module vbs_top #(
    parameter int RASTER_LINES = 263,
    parameter bit MUXED = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // video dot clock, sampled and edge detected; each rising edge advances the dot count
    input wire logic dot_clk,
    output logic phase_clk,
    // register port
    input wire logic cs_n,
    input wire logic rw,
    input wire logic [5:0] addr_in,
    output logic [5:0] addr_out,
    output logic addr_oe,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // memory interface
    output logic [12:7] addr_hi_out,
    output logic [12:0] addr_direct,
    output logic ras_n,
    output logic cas_n,
    output logic address_drive_enable,
    output logic bus_available,
    // interrupt, open drain
    output logic irq_out,
    output logic irq_oe,
    // light pen and sprite side
    input wire logic pen_input_n,
    input wire logic [7:0] sprite_data_hits,
    input wire logic [7:0] sprite_sprite_hits,
    input wire logic [7:0] sprite_active,
    input wire logic [3:0] matrix_base,
    // beam state for the display side
    output logic [8:0] beam_x,
    output logic [8:0] raster_line,
    output logic [2:0] horizontal_fine_offset,
    output logic [2:0] vertical_fine_offset,
    output logic display_window,
    output logic bad_line
);

    // refuse parameter values that the counters and the access timing cannot serve
    if (RASTER_LINES < 252 || RASTER_LINES > 512) begin : g_bad_lines
        $error("RASTER_LINES must be in 252..512");
    end
    if (`VBS_HALF_CYCLE_CLKS < 4) begin : g_slow_clk
        $error("clock too slow for a half cycle access");
    end

    localparam logic [8:0] LAST_LINE = 9'(RASTER_LINES - 1);

    // does cycle c need a video phase-2 access
    function automatic logic need_p2(input logic [5:0] c, input logic bad, input logic [7:0] act);
        logic [5:0] rel;
        logic [5:0] crel;
        rel = c - `VBS_SPR_FIRST;
        crel = c - `VBS_CHR_FIRST;
        need_p2 = (bad && c >= `VBS_CHR_FIRST && crel < `VBS_CHR_COUNT)
            || (c >= `VBS_SPR_FIRST && act[rel[3:1]]);
    endfunction : need_p2

    // ==========================================================
    // beam counters
    logic dot_prev_q;
    logic [8:0] h_q;
    logic [8:0] line_q;
    logic [8:0] line_next;
    logic tick;
    logic phase_end;
    logic line_end;
    logic frame_start;
    logic [5:0] cyc;
    logic phi0;
    logic [1:0] dot;

    assign tick = dot_clk & ~dot_prev_q;
    assign cyc = h_q[8:3];
    assign phi0 = h_q[2];
    assign dot = h_q[1:0];
    assign phase_end = tick && dot == 2'h3;
    assign line_end = tick && h_q == 9'h1FF;
    assign line_next = (line_q == LAST_LINE) ? 9'h000 : 9'(line_q + 9'h001);
    assign frame_start = line_end && line_q == LAST_LINE;

    // dot position and raster line, phase clock is bit 2 of the dot count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dot_prev_q <= 1'b0;
            h_q <= 9'h000;
            line_q <= 9'h000;
        end else begin
            dot_prev_q <= dot_clk;
            if (tick) begin
                h_q <= 9'(h_q + 9'h001);
            end
            if (line_end) begin
                line_q <= line_next;
            end
        end
    end

    assign phase_clk = phi0;
    assign beam_x = h_q;
    assign raster_line = line_q;

    // ==========================================================
    // control registers
    logic [7:0] ctrl_v_q;
    logic [7:0] ctrl_h_q;
    logic [8:0] cmp_q;
    logic [3:0] en_q;
    logic [3:0] lat_q;
    logic [3:0] lat_set;
    logic [3:0] lat_clr;
    logic irq_sum;

    assign vertical_fine_offset = ctrl_v_q[`VBS_FINE_MSB:0];
    assign horizontal_fine_offset = ctrl_h_q[`VBS_FINE_MSB:0];
    assign display_window = line_q >= `VBS_WIN_FIRST && line_q <= `VBS_WIN_LAST;
    assign bad_line = ctrl_v_q[`VBS_DEN_BIT] && display_window
        && line_q[2:0] == vertical_fine_offset;

    // ==========================================================
    // bus arbitration
    logic bus_avail_q;
    logic [1:0] ba_cnt_q;
    logic [5:0] cyc_nx;
    logic ba_low_nx;
    logic take_p2;
    logic aec;

    assign cyc_nx = 6'(cyc + 6'h01);
    // look four cycles ahead so the processor gets three phase-2 periods
    assign ba_low_nx = need_p2(cyc_nx, bad_line, sprite_active)
        || need_p2(6'(cyc_nx + 6'h01), bad_line, sprite_active)
        || need_p2(6'(cyc_nx + 6'h02), bad_line, sprite_active)
        || need_p2(6'(cyc_nx + 6'h03), bad_line, sprite_active);
    assign take_p2 = need_p2(cyc, bad_line, sprite_active) && ba_cnt_q == `VBS_BA_LEAD;
    assign aec = phi0 ? ~take_p2 : 1'b0;

    // bus-available changes only as phase 1 begins; count phase-2 ends while low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_avail_q <= 1'b1;
            ba_cnt_q <= 2'h0;
        end else if (tick && h_q[2:0] == 3'h7) begin
            bus_avail_q <= ~ba_low_nx;
            if (!ba_low_nx) begin
                ba_cnt_q <= 2'h0;
            end else if (!bus_avail_q && ba_cnt_q != `VBS_BA_LEAD) begin
                ba_cnt_q <= 2'(ba_cnt_q + 2'h1);
            end
        end
    end

    assign bus_available = bus_avail_q;
    assign address_drive_enable = aec;

    // ==========================================================
    // access kind and video address
    vbs_pkg::vbs_acc_e acc;
    logic [5:0] rel_spr;
    logic [5:0] rel_rfr;
    logic [2:0] spr_idx;
    logic in_spr;
    logic [13:0] vaddr;
    logic [7:0] rfc_q;
    logic [9:0] vc_q;
    logic [7:0] spr_ptr_q [8];
    logic [5:0] spr_mc_q [8];

    assign rel_spr = cyc - `VBS_SPR_FIRST;
    assign rel_rfr = cyc - `VBS_RFR_FIRST;
    assign spr_idx = rel_spr[3:1];
    assign in_spr = cyc >= `VBS_SPR_FIRST;

    // classify the access of the current phase
    always_comb begin
        acc = vbs_pkg::VBS_ACC_IDLE;
        if (!phi0) begin
            if (cyc >= `VBS_RFR_FIRST && rel_rfr < `VBS_RFR_COUNT) begin
                acc = vbs_pkg::VBS_ACC_RFR;
            end else if (in_spr && !rel_spr[0]) begin
                acc = vbs_pkg::VBS_ACC_SPTR;
            end else if (in_spr && sprite_active[spr_idx]) begin
                acc = vbs_pkg::VBS_ACC_SDAT;
            end
        end else if (take_p2) begin
            if (in_spr) begin
                acc = vbs_pkg::VBS_ACC_SDAT;
            end else begin
                acc = vbs_pkg::VBS_ACC_CHR;
            end
        end
    end

    // address for the chosen access
    always_comb begin
        vaddr = `VBS_IDLE_ADDR;
        case (acc)
            vbs_pkg::VBS_ACC_RFR: vaddr = {`VBS_RFR_HI, rfc_q};
            vbs_pkg::VBS_ACC_CHR: vaddr = {matrix_base, vc_q};
            vbs_pkg::VBS_ACC_SPTR: vaddr = {matrix_base, `VBS_SPTR_HI, spr_idx};
            vbs_pkg::VBS_ACC_SDAT: vaddr = {spr_ptr_q[spr_idx], spr_mc_q[spr_idx]};
            default: vaddr = `VBS_IDLE_ADDR;
        endcase
    end

    // refresh row, matrix position, sprite pointers and byte counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rfc_q <= 8'hFF;
            vc_q <= 10'h000;
            for (int i = 0; i < 8; i++) begin
                spr_ptr_q[i] <= 8'h00;
                spr_mc_q[i] <= 6'h00;
            end
        end else begin
            if (phase_end && acc == vbs_pkg::VBS_ACC_RFR) begin
                rfc_q <= 8'(rfc_q - 8'h01);
            end
            if (frame_start) begin
                vc_q <= 10'h000;
            end else if (phase_end && acc == vbs_pkg::VBS_ACC_CHR) begin
                vc_q <= 10'(vc_q + 10'h001);
            end
            for (int i = 0; i < 8; i++) begin
                if (!sprite_active[i]) begin
                    spr_mc_q[i] <= 6'h00;
                end else if (phase_end && acc == vbs_pkg::VBS_ACC_SDAT && spr_idx == 3'(i)) begin
                    spr_mc_q[i] <= 6'(spr_mc_q[i] + 6'h01);
                end
                if (phase_end && acc == vbs_pkg::VBS_ACC_SPTR && spr_idx == 3'(i)) begin
                    spr_ptr_q[i] <= data_in;
                end
            end
        end
    end

    // ==========================================================
    // dram strobes and address pins, each access inside one 500 ns phase
    logic strobe_on;
    logic col_sel;

    assign strobe_on = MUXED && (phi0 || acc != vbs_pkg::VBS_ACC_IDLE);
    assign col_sel = dot[1];
    assign ras_n = ~(strobe_on && dot != 2'h0);
    assign cas_n = ~(strobe_on && col_sel);
    assign addr_out = (MUXED && col_sel) ? vaddr[13:8] : vaddr[5:0];
    assign addr_hi_out = vaddr[12:7];
    assign addr_direct = vaddr[12:0];
    assign addr_oe = ~aec;

    // ==========================================================
    // register port
    logic access_ok;
    logic wr_stb;
    logic [7:0] rd_mux;
    logic [7:0] data_out_q;
    logic [7:0] pen_x_q;
    logic [7:0] pen_y_q;

    assign access_ok = aec && phi0 && !cs_n;
    assign wr_stb = access_ok && !rw && tick && h_q[2:0] == 3'h7;
    assign lat_clr = (wr_stb && addr_in == `VBS_OFF_IRQ_LAT) ? data_in[3:0] : 4'h0;
    assign irq_sum = |(lat_q & en_q);

    // read decode
    always_comb begin
        if (addr_in == `VBS_OFF_CTRL_V) begin
            rd_mux = {line_q[8], ctrl_v_q[6:0]};
        end else if (addr_in == `VBS_OFF_RASTER) begin
            rd_mux = line_q[7:0];
        end else if (addr_in == `VBS_OFF_PEN_X) begin
            rd_mux = pen_x_q;
        end else if (addr_in == `VBS_OFF_PEN_Y) begin
            rd_mux = pen_y_q;
        end else if (addr_in == `VBS_OFF_CTRL_H) begin
            rd_mux = ctrl_h_q;
        end else if (addr_in == `VBS_OFF_IRQ_LAT) begin
            rd_mux = {irq_sum, 3'h0, lat_q};
        end else if (addr_in == `VBS_OFF_IRQ_EN) begin
            rd_mux = {4'h0, en_q};
        end else begin
            rd_mux = `VBS_UNMAPPED;
        end
    end

    // register writes, taken as phase 2 ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_v_q <= `VBS_CTRL_V_RST;
            ctrl_h_q <= `VBS_CTRL_H_RST;
            cmp_q <= `VBS_CMP_RST;
            en_q <= `VBS_IRQ_EN_RST;
            data_out_q <= 8'h00;
        end else begin
            data_out_q <= rd_mux;
            if (wr_stb && addr_in == `VBS_OFF_CTRL_V) begin
                ctrl_v_q <= data_in;
                cmp_q[8] <= data_in[`VBS_RC8_BIT];
            end
            if (wr_stb && addr_in == `VBS_OFF_RASTER) begin
                cmp_q[7:0] <= data_in;
            end
            if (wr_stb && addr_in == `VBS_OFF_CTRL_H) begin
                ctrl_h_q <= data_in;
            end
            if (wr_stb && addr_in == `VBS_OFF_IRQ_EN) begin
                en_q <= data_in[3:0];
            end
        end
    end

    assign data_out = data_out_q;
    assign data_oe = access_ok && rw;

    // ==========================================================
    // light pen, collisions and interrupt latches
    logic pen_prev_q;
    logic pen_armed_q;
    logic pen_take;
    logic sd_any_q;
    logic ss_any_q;

    assign pen_take = pen_prev_q && !pen_input_n && pen_armed_q;
    assign lat_set[`VBS_LAT_RASTER] = line_end && line_next == cmp_q;
    assign lat_set[`VBS_LAT_SDATA] = (|sprite_data_hits) && !sd_any_q;
    assign lat_set[`VBS_LAT_SSPR] = (|sprite_sprite_hits) && !ss_any_q;
    assign lat_set[`VBS_LAT_PEN] = pen_take;

    // pen capture once per frame; latches with set winning over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pen_prev_q <= 1'b1;
            pen_armed_q <= 1'b1;
            pen_x_q <= 8'h00;
            pen_y_q <= 8'h00;
            sd_any_q <= 1'b0;
            ss_any_q <= 1'b0;
            lat_q <= 4'h0;
        end else begin
            pen_prev_q <= pen_input_n;
            if (frame_start) begin
                pen_armed_q <= 1'b1;
            end else if (pen_take) begin
                pen_armed_q <= 1'b0;
            end
            if (pen_take) begin
                pen_x_q <= h_q[8:1];
                pen_y_q <= line_q[7:0];
            end
            sd_any_q <= |sprite_data_hits;
            ss_any_q <= |sprite_sprite_hits;
            lat_q <= (lat_q & ~lat_clr) | lat_set;
        end
    end

    assign irq_out = 1'b0;
    assign irq_oe = irq_sum;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ba_fall;
        $fell(bus_avail_q) ##0 !phi0;
    endsequence

    ba_stall_a: assert property (s_ba_fall |-> ba_cnt_q == 2'h0)
        else $error("bus taken too soon after bus-available fell");
    p2_take_a: assert property (phi0 && !aec |-> !bus_avail_q && ba_cnt_q == 2'h3)
        else $error("phase-2 taken without three-period warning");
    rfr_phase_a: assert property (acc == vbs_pkg::VBS_ACC_RFR |-> !phi0 && !aec)
        else $error("refresh outside phase 1");
    chr_bad_a: assert property (acc == vbs_pkg::VBS_ACC_CHR |-> bad_line && !aec)
        else $error("pointer fetch off a bad line");
    pen_once_a: assert property (!pen_armed_q && !frame_start |=> $stable(pen_x_q) && $stable(pen_y_q))
        else $error("pen latch moved twice in a frame");
    pen_cap_a: assert property (pen_take |=> pen_x_q == $past(h_q[8:1]) && pen_y_q == $past(line_q[7:0]))
        else $error("pen latch holds wrong position");
    w1c_hold_a: assert property (lat_q[0] && !(wr_stb && addr_in == `VBS_OFF_IRQ_LAT && data_in[0]) |=> lat_q[0])
        else $error("raster latch cleared without a written one");
    raster_cmp_a: assert property (line_end && line_next == cmp_q |=> lat_q[0] ##1 lat_q[0] || $past(lat_clr[0], 1))
        else $error("raster match did not set latch");
    irq_pin_a: assert property (lat_set[3] && en_q[3]
        |=> irq_oe && (addr_in != `VBS_OFF_IRQ_LAT || rd_mux[7]))
        else $error("irq pin and summary disagree");
    coll_once_a: assert property (sd_any_q && (|sprite_data_hits) && !lat_q[1] |=> !lat_q[1])
        else $error("collision latch set again before clear");
    phase_div_a: assert property ($changed(phase_clk) |-> $past(tick && dot == 2'h3))
        else $error("phase clock moved off the dot divider");

endmodule : vbs_top
`default_nettype wire

/* rtl/vbs_defs.svh */
// constants for the video bus-share, raster and interrupt block
`ifndef VBS_DEFS_SVH
`define VBS_DEFS_SVH

// ==========================================================
// register offsets
`define VBS_OFF_CTRL_V 6'h11
`define VBS_OFF_RASTER 6'h12
`define VBS_OFF_PEN_X 6'h13
`define VBS_OFF_PEN_Y 6'h14
`define VBS_OFF_CTRL_H 6'h16
`define VBS_OFF_IRQ_LAT 6'h19
`define VBS_OFF_IRQ_EN 6'h1A

// ==========================================================
// field positions and reset values
`define VBS_FINE_MSB 2
`define VBS_DEN_BIT 4
`define VBS_RC8_BIT 7
`define VBS_SUM_BIT 7
`define VBS_LAT_RASTER 0
`define VBS_LAT_SDATA 1
`define VBS_LAT_SSPR 2
`define VBS_LAT_PEN 3
`define VBS_CTRL_V_RST 8'h00
`define VBS_CTRL_H_RST 8'h00
`define VBS_IRQ_EN_RST 4'h0
`define VBS_CMP_RST 9'h000
`define VBS_UNMAPPED 8'hFF

// ==========================================================
// raster window and cycle slots within a line
`define VBS_WIN_FIRST 9'h033
`define VBS_WIN_LAST 9'h0FB
`define VBS_RFR_FIRST 6'h0B
`define VBS_RFR_COUNT 6'h05
`define VBS_CHR_FIRST 6'h07
`define VBS_CHR_COUNT 6'h28
`define VBS_SPR_FIRST 6'h30
`define VBS_BA_LEAD 2'h3
`define VBS_IDLE_ADDR 14'h3FFF
`define VBS_RFR_HI 6'h3F
`define VBS_SPTR_HI 7'h7F

// ==========================================================
// timing
`define VBS_CLK_NS 10
`define VBS_HALF_CYCLE_NS 500
`define VBS_HALF_CYCLE_CLKS (`VBS_HALF_CYCLE_NS / `VBS_CLK_NS)

`endif

/* rtl/vbs_pkg.sv */
// types for the video bus-share, raster and interrupt block
package vbs_pkg;
    // ==========================================================
    // kind of video memory access in the current phase
    typedef enum logic [4:0] {
        VBS_ACC_IDLE = 5'h01,
        VBS_ACC_RFR = 5'h02,
        VBS_ACC_CHR = 5'h04,
        VBS_ACC_SPTR = 5'h08,
        VBS_ACC_SDAT = 5'h10
    } vbs_acc_e;
endpackage : vbs_pkg

/* verification/vbs_partner.sv */
// dram and processor stand-in on the far side of the shared bus
`timescale 1ns/1ps
`default_nettype none
module vbs_partner (
    // clock
    input wire logic clk,
    // video memory strobes, address and stall request
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic [5:0] addr_out,
    input wire logic bus_available,
    // read data and processor readiness
    output logic [7:0] mem_data,
    output logic cpu_ready
);
    logic [5:0] row_q = 6'h00;
    logic [7:0] last_q = 8'h5A;
    logic ras_q = 1'b1;
    logic cas_q = 1'b1;
    // dram: row taken on ras fall, column on cas fall
    always @(posedge clk) begin
        ras_q <= ras_n;
        cas_q <= cas_n;
        if (ras_q && !ras_n) row_q <= addr_out;
        if (cas_q && !cas_n) last_q <= {row_q[3:0], addr_out[3:0]};
    end
    // data only while cas is low, else a changed pattern
    assign mem_data = cas_n ? ~last_q : last_q;
    // processor makes no new bus use once a stall is asked for
    assign cpu_ready = bus_available;
endmodule : vbs_partner
`default_nettype wire

/* verification/vbs_top_tb.sv */
// self-checking bench for the bus-share, raster and interrupt block
`timescale 1ns/1ps
`default_nettype none
module vbs_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dot_clk = 1'b0;
    logic cs_n = 1'b1;
    logic rw = 1'b1;
    logic [5:0] addr_in = 6'h00;
    logic [7:0] cpu_data = 8'h00;
    logic pen_n = 1'b1;
    logic [7:0] hit_d = 8'h00;
    logic [7:0] hit_s = 8'h00;
    logic [7:0] spr_act = 8'h00;
    logic [5:0] addr_out;
    logic [7:0] data_out;
    logic [12:7] addr_hi_out;
    logic [12:0] addr_direct;
    logic phase_clk, ras_n, cas_n, address_drive_enable, bus_available, irq_oe, display_window, bad_line;
    logic [8:0] beam_x, raster_line;
    logic [2:0] h_fine, v_fine;
    logic [7:0] mem_data;
    logic cpu_ready, data_oe, addr_oe, irq_out;
    wire logic [7:0] data_in = address_drive_enable ? cpu_data : mem_data;
    int fails = 0;
    int samples_checked = 0;

    // ==========================================================
    // clocks, design and far side
    initial forever #5 clk = ~clk;
    initial forever #10 dot_clk = ~dot_clk;
    vbs_top #(.RASTER_LINES(263), .MUXED(1'b1)) i_vbs_top (.clk(clk), .rst(rst), .dot_clk(dot_clk),
        .phase_clk(phase_clk), .cs_n(cs_n), .rw(rw), .addr_in(addr_in), .addr_out(addr_out), .addr_oe(addr_oe),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .addr_hi_out(addr_hi_out),
        .addr_direct(addr_direct), .ras_n(ras_n), .cas_n(cas_n), .address_drive_enable(address_drive_enable),
        .bus_available(bus_available), .irq_out(irq_out), .irq_oe(irq_oe), .pen_input_n(pen_n),
        .sprite_data_hits(hit_d), .sprite_sprite_hits(hit_s), .sprite_active(spr_act), .matrix_base(4'h4),
        .beam_x(beam_x), .raster_line(raster_line), .horizontal_fine_offset(h_fine),
        .vertical_fine_offset(v_fine), .display_window(display_window), .bad_line(bad_line));
    vbs_partner i_vbs_partner (.clk(clk), .ras_n(ras_n), .cas_n(cas_n), .addr_out(addr_out),
        .bus_available(bus_available), .mem_data(mem_data), .cpu_ready(cpu_ready));

    // ==========================================================
    // compare, verdict and bounded clock step
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic step(inout int n);
        @(posedge clk);
        #1;
        n++;
        if (n > 70000) begin
            fails++;
            $display("mismatch wait expected done seen timeout");
            stop_test;
        end
    endtask : step

    // ==========================================================
    // one register cycle inside a processor phase 2
    task automatic reg_acc(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        while (phase_clk !== 1'b0) step(n);
        while (!(phase_clk === 1'b1 && address_drive_enable === 1'b1 && cpu_ready === 1'b1)) step(n);
        cs_n = 1'b0;
        rw = ~wr;
        addr_in = a;
        cpu_data = d;
        repeat (3) step(n);
        check("data drive", 16'(!wr), 16'(data_oe));
        q = data_out;
        while (phase_clk !== 1'b0) step(n);
        cs_n = 1'b1;
        rw = 1'b1;
    endtask : reg_acc
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        reg_acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        reg_acc(1'b0, a, 8'h00, q);
        check(what, {8'h00, exp}, {8'h00, q});
    endtask : rd
    task automatic wait_line;
        logic [8:0] l;
        int n;
        n = 0;
        l = raster_line;
        while (raster_line === l) step(n);
        // one more edge so the bus monitor has closed the finished line
        step(n);
    endtask : wait_line

    // ==========================================================
    // bus monitor: stall lead, phase 1 ownership, address layout, counts per line
    logic ras_q = 1'b1;
    logic ph_q = 1'b0;
    logic took = 1'b0;
    logic [8:0] line_q = 9'h000;
    int ba_cnt = 0, ras_cnt = 0, takes = 0, line_ras = 0, line_takes = 0, chr_n = 0;
    always @(posedge clk) begin
        if (!rst) begin
            if (ras_q && !ras_n) ras_cnt++;
            if (phase_clk && !address_drive_enable && !took && bad_line) begin
                check("pointer addr", 16'(chr_n), 16'(addr_direct[9:0]));
                chr_n++;
            end
            if (phase_clk && !address_drive_enable) took = 1'b1;
            if (!ph_q && phase_clk) ba_cnt = bus_available ? 0 : ba_cnt + 1;
            if (ph_q && !phase_clk) begin
                if (took) takes++;
                if (took) check("stall lead", 16'h0001, 16'(ba_cnt >= 4));
                took = 1'b0;
            end
            if (!ph_q && !phase_clk) check("phase one owner", 16'h0000, 16'(address_drive_enable));
            if (!ras_n && cas_n && !address_drive_enable) check("row pins", 16'(addr_direct[5:0]), 16'(addr_out));
            if (!cas_n && !address_drive_enable) check("col pins", 16'(addr_direct[12:8]), 16'(addr_out[4:0]));
            if (!address_drive_enable) check("static pins", 16'(addr_direct[12:7]), 16'(addr_hi_out));
            check("addr drive", 16'(!address_drive_enable), 16'(addr_oe));
            if (line_q != raster_line) begin
                line_ras = ras_cnt;
                line_takes = takes;
                ras_cnt = 0;
                takes = 0;
            end
            line_q = raster_line;
            ras_q = ras_n;
            ph_q = phase_clk;
        end
    end

    // ==========================================================
    // scenarios
    task automatic t_regs;
        rd(6'h1A, 8'h00, "enables reset");
        rd(6'h19, 8'h00, "latches reset");
        rd(6'h3F, 8'hFF, "unmapped");
        wr(6'h13, 8'h55);
        rd(6'h13, 8'h00, "pen x read only");
        wr(6'h16, 8'h05);
        wr(6'h11, 8'h03);
        check("h fine", 16'h0005, 16'(h_fine));
        check("v fine", 16'h0003, 16'(v_fine));
        rd(6'h16, 8'h05, "h fine read");
        rd(6'h11, 8'h03, "rc8 read");
        rd(6'h12, raster_line[7:0], "raster low");
    endtask : t_regs
    task automatic t_raster;
        logic [8:0] t;
        int n;
        n = 0;
        t = raster_line + 9'h002;
        wr(6'h12, t[7:0]);
        wr(6'h11, {t[8], 7'h03});
        wr(6'h1A, 8'h01);
        while (irq_oe !== 1'b1) step(n);
        check("match line", 16'(t), 16'(raster_line));
        rd(6'h19, 8'h81, "raster latch");
        wr(6'h19, 8'h00);
        rd(6'h19, 8'h81, "zero write");
        wr(6'h19, 8'h01);
        rd(6'h19, 8'h00, "once per line");
        check("irq released", 16'h0000, 16'(irq_oe));
    endtask : t_raster
    task automatic put(input logic s, input logic [7:0] v);
        int n;
        n = 0;
        if (s) hit_s = v;
        else hit_d = v;
        repeat (2) step(n);
    endtask : put
    task automatic t_hit(input logic s);
        logic [7:0] e;
        e = s ? 8'h04 : 8'h02;
        put(s, 8'h01);
        rd(6'h19, e, "hit first");
        check("masked irq", 16'h0000, 16'(irq_oe));
        wr(6'h19, e);
        put(s, 8'h03);
        rd(6'h19, 8'h00, "hit again");
        put(s, 8'h00);
        put(s, 8'h80);
        rd(6'h19, e, "hit rearmed");
        wr(6'h19, e);
        put(s, 8'h00);
    endtask : t_hit
    task automatic t_pen;
        logic [7:0] x, y;
        int n;
        n = 0;
        wr(6'h1A, 8'h08);
        while (beam_x[0] !== 1'b1) step(n);
        while (beam_x[0] !== 1'b0) step(n);
        x = beam_x[8:1];
        y = raster_line[7:0];
        pen_n = 1'b0;
        repeat (3) step(n);
        check("pen irq", 16'h0001, 16'(irq_oe));
        check("irq level", 16'h0000, 16'(irq_out));
        rd(6'h13, x, "pen x");
        rd(6'h14, y, "pen y");
        rd(6'h19, 8'h88, "pen latch");
        pen_n = 1'b1;
        wr(6'h19, 8'h08);
        pen_n = 1'b0;
        repeat (40) step(n);
        pen_n = 1'b1;
        rd(6'h19, 8'h00, "pen once");
        rd(6'h13, x, "pen kept");
    endtask : t_pen
    task automatic t_fetch;
        int n;
        n = 0;
        spr_act = 8'h81;
        wait_line;
        wait_line;
        check("strobes sprites", 16'd79, 16'(line_ras));
        check("takes sprites", 16'h0004, 16'(line_takes));
        spr_act = 8'h00;
        wait_line;
        wait_line;
        check("strobes idle", 16'd77, 16'(line_ras));
        check("takes idle", 16'h0000, 16'(line_takes));
        wr(6'h11, 8'h10);
        while (bad_line !== 1'b1) step(n);
        check("first bad line", 16'h0038, 16'(raster_line));
        check("window", 16'h0001, 16'(display_window));
        wait_line;
        check("takes bad line", 16'h0028, 16'(line_takes));
    endtask : t_fetch

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        t_regs();
        t_raster();
        t_hit(1'b0);
        t_hit(1'b1);
        t_pen();
        t_fetch();
        stop_test();
    end
endmodule : vbs_top_tb
`default_nettype wire
